// File: pio_pkg.sv
// constants for the parallel i/o ports 0 to 3 and their apb register map
package pio_pkg;
	// register indices, byte address is four times the index
	localparam logic [5:0] PORT0_OUTPUT_LATCH_IDX  = 6'h00;
	localparam logic [5:0] PORT1_OUTPUT_LATCH_IDX  = 6'h01;
	localparam logic [5:0] PORT2_OUTPUT_LATCH_IDX  = 6'h02;
	localparam logic [5:0] PORT3_OUTPUT_LATCH_IDX  = 6'h03;
	localparam logic [5:0] PORT0_DIRECTION_IDX     = 6'h08;
	localparam logic [5:0] PORT1_DIRECTION_IDX     = 6'h09;
	localparam logic [5:0] PORT3_DIRECTION_IDX     = 6'h0b;
	localparam logic [5:0] PORT2_PIN_INPUT_IDX     = 6'h2c;
	localparam logic [5:0] SYSTEM_CONTROL_ONE_IDX  = 6'h38;
	localparam logic [5:0] SYSTEM_CONTROL_TWO_IDX  = 6'h39;

	// widths
	localparam int         PORT_WIDTH              = 8;
	localparam int         PORT2_WIDTH             = 3;
	localparam int         APB_ADDR_WIDTH          = 8;

	// reset values
	localparam logic [7:0] PORT0_LATCH_RESET       = 8'h00;
	localparam logic [7:0] PORT1_LATCH_RESET       = 8'h00;
	localparam logic [2:0] PORT2_LATCH_RESET       = 3'h7;
	localparam logic [7:0] PORT3_LATCH_RESET       = 8'hff;
	localparam logic [7:0] DIRECTION_RESET         = 8'h00;
	localparam logic [7:0] SYSTEM_CONTROL_RESET    = 8'h00;

	// field positions in the system control registers
	localparam int         STOP_MODE_BIT           = 7;
	localparam int         STOP_OUTPUT_HOLD_BIT    = 4;
	localparam int         LOW_FREQ_OSC_ENABLE_BIT = 6;

	// port two bit roles
	localparam int         STOP_RELEASE_BIT        = 0;
	localparam int         SLOW_CRYSTAL_IN_BIT     = 1;
	localparam int         SLOW_CRYSTAL_OUT_BIT    = 2;
endpackage : pio_pkg

// File: pio_ports.sv
// apb-attached parallel i/o ports 0 to 3 with direction, stop-mode and oscillator pin sharing
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// Summary of operation
// - every output pin has a holding latch
// - pins are sampled unlatched at read setup
// - write updates latch in access phase
// - port0 direction and latch reset to zero
// - port1 direction and latch reset to zero
// - port2 three bits, latches reset to one
// - port2 latch and pins at separate addresses
// - port2 pin read defines only low bits
// - slow oscillator takes port2 bits one, two
// - port2 bit zero floats in stop mode
// - port3 direction zero, latch ones at reset
// - shared-address read returns pins for inputs
module pio_ports (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  port0_pin_in,
	output logic      [7:0]  port0_pin_out,
	output logic      [7:0]  port0_pin_oe_n,
	input  wire logic [7:0]  port1_pin_in,
	output logic      [7:0]  port1_pin_out,
	output logic      [7:0]  port1_pin_oe_n,
	input  wire logic [2:0]  port2_pin_in,
	output logic      [2:0]  port2_pin_out,
	output logic      [2:0]  port2_pin_oe_n,
	input  wire logic [7:0]  port3_pin_in,
	output logic      [7:0]  port3_pin_out,
	output logic      [7:0]  port3_pin_oe_n,
	output logic             stop_mode,
	output logic             low_freq_osc_enable
);

	// shared-address read: output bits show the latch, input bits the live pin
	function automatic logic [7:0] pio_shared_read(
		input logic [7:0] dir,
		input logic [7:0] latch,
		input logic [7:0] pin
	);
		pio_shared_read = (dir & latch) | (~dir & pin);
	endfunction : pio_shared_read

	// active-low enable: drive only output-mode bits that stop mode allows
	function automatic logic [7:0] pio_drive_oe_n(
		input logic [7:0] dir,
		input logic       allow
	);
		pio_drive_oe_n = ~(dir & {8{allow}});
	endfunction : pio_drive_oe_n

	// word match for one register index
	function automatic logic pio_hit(
		input logic [7:0] addr,
		input logic [5:0] idx
	);
		pio_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
	endfunction : pio_hit

	// output latches, direction registers and system control words
	logic [7:0] port0_output_latch;
	logic [7:0] port1_output_latch;
	logic [2:0] port2_output_latch;
	logic [7:0] port3_output_latch;
	logic [7:0] port0_direction;
	logic [7:0] port1_direction;
	logic [7:0] port3_direction;
	logic [7:0] system_control_one;
	logic [7:0] system_control_two;

	// address decode: output latches
	wire        hit_p0_latch  = pio_hit(paddr, pio_pkg::PORT0_OUTPUT_LATCH_IDX);
	wire        hit_p1_latch  = pio_hit(paddr, pio_pkg::PORT1_OUTPUT_LATCH_IDX);
	wire        hit_p2_latch  = pio_hit(paddr, pio_pkg::PORT2_OUTPUT_LATCH_IDX);
	wire        hit_p3_latch  = pio_hit(paddr, pio_pkg::PORT3_OUTPUT_LATCH_IDX);

	// address decode: direction registers and port two pins
	wire        hit_p0_dir    = pio_hit(paddr, pio_pkg::PORT0_DIRECTION_IDX);
	wire        hit_p1_dir    = pio_hit(paddr, pio_pkg::PORT1_DIRECTION_IDX);
	wire        hit_p3_dir    = pio_hit(paddr, pio_pkg::PORT3_DIRECTION_IDX);
	wire        hit_p2_pins   = pio_hit(paddr, pio_pkg::PORT2_PIN_INPUT_IDX);

	// address decode: system control words
	wire        hit_sys_one   = pio_hit(paddr, pio_pkg::SYSTEM_CONTROL_ONE_IDX);
	wire        hit_sys_two   = pio_hit(paddr, pio_pkg::SYSTEM_CONTROL_TWO_IDX);

	// legal targets and refused accesses
	wire        hit_writable  = hit_p0_latch | hit_p1_latch | hit_p2_latch |
	                            hit_p3_latch | hit_p0_dir | hit_p1_dir |
	                            hit_p3_dir | hit_sys_one | hit_sys_two;
	wire        hit_any       = hit_writable | hit_p2_pins;
	wire        bad_access    = !hit_any || (pwrite && hit_p2_pins);

	// bus phases: setup samples pins, access commits the write
	wire        setup_phase   = psel && !penable;
	wire        access_phase  = psel && penable;

	// write strobe and the byte that carries the register data
	wire        wr_commit     = access_phase && pwrite && pstrb[0] && !bad_access;
	wire [7:0]  wr_byte       = pwdata[7:0];

	// read strobe: pins and registers are captured at the setup edge
	wire        rd_capture    = setup_phase && !pwrite;

	// writable bits of the system control words
	wire [7:0]  sys_one_mask  = (8'h01 << pio_pkg::STOP_MODE_BIT) | (8'h01 << pio_pkg::STOP_OUTPUT_HOLD_BIT);
	wire [7:0]  sys_two_mask  = 8'h01 << pio_pkg::LOW_FREQ_OSC_ENABLE_BIT;

	// mode bits
	wire        stop_bit      = system_control_one[pio_pkg::STOP_MODE_BIT];
	wire        hold_bit      = system_control_one[pio_pkg::STOP_OUTPUT_HOLD_BIT];
	wire        osc_bit       = system_control_two[pio_pkg::LOW_FREQ_OSC_ENABLE_BIT];

	// stop mode releases the drivers unless output hold is set
	wire        drive_allowed = !stop_bit || hold_bit;

	// read view of each register, shared-address ports mix latch and pins
	wire [7:0]  rd_p0_latch   = pio_shared_read(port0_direction, port0_output_latch, port0_pin_in);
	wire [7:0]  rd_p1_latch   = pio_shared_read(port1_direction, port1_output_latch, port1_pin_in);
	wire [7:0]  rd_p3_latch   = pio_shared_read(port3_direction, port3_output_latch, port3_pin_in);
	wire [7:0]  rd_p2_latch   = {5'h00, port2_output_latch};
	wire [7:0]  rd_p2_pins    = {5'h00, port2_pin_in};

	// read data selection, port two upper bits read as zero
	logic [7:0] rd_byte;
	always_comb begin
		if (hit_p0_latch) begin
			rd_byte = rd_p0_latch;
		end else if (hit_p1_latch) begin
			rd_byte = rd_p1_latch;
		end else if (hit_p3_latch) begin
			rd_byte = rd_p3_latch;
		end else if (hit_p2_latch) begin
			rd_byte = rd_p2_latch;
		end else if (hit_p2_pins) begin
			rd_byte = rd_p2_pins;
		end else if (hit_p0_dir) begin
			rd_byte = port0_direction;
		end else if (hit_p1_dir) begin
			rd_byte = port1_direction;
		end else if (hit_p3_dir) begin
			rd_byte = port3_direction;
		end else if (hit_sys_one) begin
			rd_byte = system_control_one & sys_one_mask;
		end else if (hit_sys_two) begin
			rd_byte = system_control_two & sys_two_mask;
		end else begin
			rd_byte = 8'h00;
		end
	end

	// read data captured in the setup cycle, the first state of the read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_capture) begin
			prdata <= {24'h00_0000, rd_byte};
		end
	end

	// zero-wait answer, error on unmapped or read-only target
	assign pready  = access_phase;
	assign pslverr = access_phase && bad_access;

	// write enables for the output latches
	wire        wr_p0_latch   = wr_commit && hit_p0_latch;
	wire        wr_p1_latch   = wr_commit && hit_p1_latch;
	wire        wr_p2_latch   = wr_commit && hit_p2_latch;
	wire        wr_p3_latch   = wr_commit && hit_p3_latch;

	// write enables for directions and system control
	wire        wr_p0_dir     = wr_commit && hit_p0_dir;
	wire        wr_p1_dir     = wr_commit && hit_p1_dir;
	wire        wr_p3_dir     = wr_commit && hit_p3_dir;
	wire        wr_sys_one    = wr_commit && hit_sys_one;
	wire        wr_sys_two    = wr_commit && hit_sys_two;

	// port zero output latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port0_output_latch <= pio_pkg::PORT0_LATCH_RESET;
		end else if (wr_p0_latch) begin
			port0_output_latch <= wr_byte;
		end
	end

	// port zero direction, all inputs after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port0_direction <= pio_pkg::DIRECTION_RESET;
		end else if (wr_p0_dir) begin
			port0_direction <= wr_byte;
		end
	end

	// port one output latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port1_output_latch <= pio_pkg::PORT1_LATCH_RESET;
		end else if (wr_p1_latch) begin
			port1_output_latch <= wr_byte;
		end
	end

	// port one direction, all inputs after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port1_direction <= pio_pkg::DIRECTION_RESET;
		end else if (wr_p1_dir) begin
			port1_direction <= wr_byte;
		end
	end

	// port two output latch, three bits set after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port2_output_latch <= pio_pkg::PORT2_LATCH_RESET;
		end else if (wr_p2_latch) begin
			port2_output_latch <= wr_byte[2:0];
		end
	end

	// port three output latch, all ones after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port3_output_latch <= pio_pkg::PORT3_LATCH_RESET;
		end else if (wr_p3_latch) begin
			port3_output_latch <= wr_byte;
		end
	end

	// port three direction, all inputs after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port3_direction <= pio_pkg::DIRECTION_RESET;
		end else if (wr_p3_dir) begin
			port3_direction <= wr_byte;
		end
	end

	// stop mode and output hold bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_control_one <= pio_pkg::SYSTEM_CONTROL_RESET;
		end else if (wr_sys_one) begin
			system_control_one <= wr_byte & sys_one_mask;
		end
	end

	// slow oscillator enable bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_control_two <= pio_pkg::SYSTEM_CONTROL_RESET;
		end else if (wr_sys_two) begin
			system_control_two <= wr_byte & sys_two_mask;
		end
	end

	// pin values come straight from the latches
	assign port0_pin_out = port0_output_latch;
	assign port1_pin_out = port1_output_latch;
	assign port2_pin_out = port2_output_latch;
	assign port3_pin_out = port3_output_latch;

	// direction ports drive only in output mode and when stop mode permits
	assign port0_pin_oe_n = pio_drive_oe_n(port0_direction, drive_allowed);
	assign port1_pin_oe_n = pio_drive_oe_n(port1_direction, drive_allowed);
	assign port3_pin_oe_n = pio_drive_oe_n(port3_direction, drive_allowed);

	// port two sinks low for a zero latch, releases for a one so the pin can be read
	wire [2:0] p2_sink = ~port2_output_latch;
	wire       p2_osc  = osc_bit;

	// per-bit sink permission, the stop release pin always floats in stop mode
	wire       p2_bit0_on = p2_sink[0] && !stop_bit;
	wire       p2_bit1_on = p2_sink[1] && drive_allowed && !p2_osc;
	wire       p2_bit2_on = p2_sink[2] && drive_allowed && !p2_osc;

	// active-low enables for port two
	assign port2_pin_oe_n[pio_pkg::STOP_RELEASE_BIT]     = !p2_bit0_on;
	assign port2_pin_oe_n[pio_pkg::SLOW_CRYSTAL_IN_BIT]  = !p2_bit1_on;
	assign port2_pin_oe_n[pio_pkg::SLOW_CRYSTAL_OUT_BIT] = !p2_bit2_on;

	// mode status seen by the rest of the chip
	assign stop_mode           = stop_bit;
	assign low_freq_osc_enable = p2_osc;

endmodule : pio_ports

// File: pio_ports_sva.sv
// concurrent checks on the apb and pin ports of the parallel i/o block
`timescale 1ns/1ps
module pio_ports_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  port0_pin_out,
	input wire logic [7:0]  port0_pin_oe_n,
	input wire logic [2:0]  port2_pin_in,
	input wire logic [2:0]  port2_pin_oe_n,
	input wire logic        stop_mode,
	input wire logic        low_freq_osc_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase and read setup
	wire acc = psel && penable;
	wire rd_set = psel && !penable && !pwrite;
	a_ready_access: assert property (acc |-> pready) else $error("no ready");
	a_bad_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned ok");
	a_pin_write: assert property (acc && pwrite && paddr == 8'hb0 |-> pslverr) else $error("pin write ok");
	a_latch_hold: assert property (!(acc && pwrite) |=> $stable(port0_pin_out)) else $error("latch moved");
	a_pin_read: assert property (rd_set && paddr == 8'hb0 |=> prdata == {29'h0, $past(port2_pin_in)})
		else $error("pin read");
	a_stop_float: assert property (stop_mode |-> port2_pin_oe_n[0]) else $error("bit0 driven");
	a_osc_pins: assert property (low_freq_osc_enable |-> port2_pin_oe_n[2:1] == 2'h3) else $error("osc driven");
	a_reset_port0: assert property ($rose(presetn) |-> port0_pin_out == 8'h00 && port0_pin_oe_n == 8'hff)
		else $error("p0 reset");
endmodule : pio_ports_chk
bind pio_ports pio_ports_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pin_out(port0_pin_out),
	.port0_pin_oe_n(port0_pin_oe_n), .port2_pin_in(port2_pin_in), .port2_pin_oe_n(port2_pin_oe_n),
	.stop_mode(stop_mode), .low_freq_osc_enable(low_freq_osc_enable));

// File: pio_pin_model.sv
// outside pin model: released pins show the outside level
`timescale 1ns/1ps
module pio_pin_model #(parameter int W = 8) (
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] oe_n,
	input  wire logic [W-1:0] ext,
	output logic      [W-1:0] pin
);
	// driven bits follow the port, released bits the outside source
	assign pin = (~oe_n & pin_out) | (oe_n & ext);
endmodule : pio_pin_model

// File: pio_ports_tb.sv
// self-checking bench for the parallel i/o ports
`timescale 1ns/1ps
module pio_ports_tb;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, err, stop_mode, osc_en;
	logic [7:0]  paddr = 8'h00, e0 = 8'h5a, p0i, p0o, p0e, p1i, p1o, p1e, p3i, p3o, p3e;
	logic [2:0]  e2 = 3'h5, p2i, p2o, p2e;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int          failures = 0, cmp_count = 0;
	// address, write data, expected read
	logic [23:0] rows [8] = '{24'h20f0f0, 24'h003c3a, 24'h24ffff, 24'h04a5a5,
		24'h2cafaf, 24'h0c81d1, 24'he44040, 24'he01010};
	pio_ports dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pin_in(p0i),
		.port0_pin_out(p0o), .port0_pin_oe_n(p0e), .port1_pin_in(p1i), .port1_pin_out(p1o), .port1_pin_oe_n(p1e),
		.port2_pin_in(p2i), .port2_pin_out(p2o), .port2_pin_oe_n(p2e), .port3_pin_in(p3i), .port3_pin_out(p3o),
		.port3_pin_oe_n(p3e), .stop_mode(stop_mode), .low_freq_osc_enable(osc_en));
	// outside pins, clock and hang watchdog
	pio_pin_model m0_u (.pin_out(p0o), .oe_n(p0e), .ext(e0), .pin(p0i));
	pio_pin_model m1_u (.pin_out(p1o), .oe_n(p1e), .ext(e0), .pin(p1i));
	pio_pin_model m3_u (.pin_out(p3o), .oe_n(p3e), .ext(e0), .pin(p3i));
	pio_pin_model #(.W(3)) m2_u (.pin_out(p2o), .oe_n(p2e), .ext(e2), .pin(p2i));
	always #10 pclk = ~pclk;
	initial #100us conclude(1);
	// compare and count
	task automatic chk(input string nm, input logic [55:0] seen, exp);
		cmp_count++;
		if (seen !== exp) $display("BAD %s expected %h seen %h", nm, exp, seen);
		failures += int'(seen !== exp);
	endtask : chk
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		{err, rd} = {pslverr, prdata};
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask : apb
	// verdict
	task automatic conclude(input int extra);
		failures += extra;
		if (failures == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// reset, register table, then stop, error and read-modify-write cases
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(1'b1, rows[i][23:16], {24'h0, rows[i][15:8]}, 4'h1);
			apb(1'b0, rows[i][23:16], 32'h0, 4'h0);
			chk("readback", rd, {24'h0, rows[i][7:0]});
		end
		chk("pins", {p0e, p0o, p1e, p1o, p3e, p3o}, 48'h0f3c00a55081);
		apb(1'b1, 8'h08, 32'h0, 4'h1);
		chk("osc", {osc_en, p2o, p2e}, 7'h46);
		apb(1'b1, 8'he0, 32'h90, 4'h1);
		chk("hold", {stop_mode, p2e, p0e}, 12'hf0f);
		apb(1'b1, 8'he0, 32'h80, 4'h1);
		chk("float", {p2e, p0e, p1e}, 19'h7ffff);
		apb(1'b1, 8'h08, 32'h7, 4'h1);
		apb(1'b0, 8'hb0, 32'h0, 4'h0);
		chk("pinread", rd, 32'h5);
		apb(1'b0, 8'h14, 32'h0, 4'h0);
		chk("unmapped", {err, rd}, 33'h100000000);
		apb(1'b1, 8'hb0, 32'h0, 4'h1);
		apb(1'b1, 8'h01, 32'hff, 4'h1);
		chk("misaligned", {err, p0o}, 9'h13c);
		e0 <= 8'ha5;
		apb(1'b0, 8'h00, 32'h0, 4'h0);
		chk("rmwread", rd, 32'h35);
		apb(1'b1, 8'h00, rd, 4'h1);
		chk("rmwwrite", p0o, 8'h35);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("reset", {p0e, p0o, p1e, p1o, p3e, p3o, p2o, p2e, stop_mode, osc_en}, 56'hff00ff00fffffc);
		conclude(0);
	end
endmodule : pio_ports_tb
